// File: rtl/vector_address_calc.sv
// Boot start, reset entry and vector address arithmetic.
// Assumes static fuse inputs.
`timescale 1ns/1ps
`default_nettype none
`include "vector_placement_defs.svh"

module vector_address_calc
   import vector_placement_pkg::*;
(
   input  wire logic [1:0]                 boot_size_fuses_in,   // Boot size fuse code
   input  wire logic                       boot_reset_fuse_in,   // 0 = programmed
   input  wire logic                       vector_base_select_in,// 1 = boot section
   input  wire logic [`VEC_NUM_W-1:0]      irq_num_in,           // Vector number
   output logic      [`FLASH_ADDR_W-1:0]   vector_base_out,      // Table base
   output logic      [`FLASH_ADDR_W-1:0]   vector_addr_out,      // Vector word address
   output logic      [`FLASH_ADDR_W-1:0]   reset_addr_out        // Reset entry
);

   // --------------------------------------------------------------------
   // Boot section start from the size fuses
   // --------------------------------------------------------------------
   function automatic logic [`FLASH_ADDR_W-1:0] boot_start_of(input logic [1:0] code);
      logic [`FLASH_ADDR_W-1:0] addr;
      unique case (code)
         2'h0: addr = `BOOT_START_SZ0;   // Largest boot section
         2'h1: addr = `BOOT_START_SZ1;
         2'h2: addr = `BOOT_START_SZ2;
         2'h3: addr = `BOOT_START_SZ3;   // Smallest boot section
      endcase
      return addr;
   endfunction : boot_start_of

   logic [`FLASH_ADDR_W-1:0] boot_start;   // Decoded boot start

   // Boot start feeds base and boot reset entry
   always_comb begin
      boot_start      = boot_start_of(boot_size_fuses_in);
      vector_base_out = vector_base_select_in ? boot_start : `FLASH_RESET_ADDR;
      // Vector n sits n words above the base; numbers out of range give the base
      if (irq_num_in >= `FIRST_VECTOR && irq_num_in <= `LAST_VECTOR) begin
         vector_addr_out = vector_base_out + {{(`FLASH_ADDR_W-`VEC_NUM_W){1'b0}}, irq_num_in};
      end else begin
         vector_addr_out = vector_base_out;
      end
      // Programmed fuse (0) enters at boot start, unprogrammed at zero
      reset_addr_out  = boot_reset_fuse_in ? `FLASH_RESET_ADDR : boot_start;
   end

endmodule : vector_address_calc
`default_nettype wire

// File: rtl/vector_placement_defs.svh
// Offsets, fields, reset values and timing counts of vector placement.
// Assumes inclusion by bare name.
`ifndef VECTOR_PLACEMENT_DEFS_SVH
`define VECTOR_PLACEMENT_DEFS_SVH

// ------------------------------------
// Bus geometry
// ------------------------------------
`define APB_ADDR_W          12
`define APB_DATA_W          32
`define CTRL_OFFSET         12'h000
`define STATUS_OFFSET       12'h004

// ------------------------------------
// Control register layout
// ------------------------------------
`define CTRL_W              8
`define CTRL_RESET          8'h00
`define BIT_UNLOCK          0
`define BIT_VSEL            1
`define BIT_IRQ0_EN         6
`define BIT_IRQ1_EN         7

// ------------------------------------
// Status register layout
// ------------------------------------
`define ST_SEQ_MASK         0
`define ST_LOCK_BLOCK       1
`define ST_HOLD             2
`define ST_CNT_LSB          4
`define ST_BASE_LSB         16

// ------------------------------------
// Flash addresses (word addresses) and vector numbering
// ------------------------------------
`define FLASH_ADDR_W        12
`define FLASH_RESET_ADDR    12'h000
`define BOOT_START_SZ0      12'hc00
`define BOOT_START_SZ1      12'he00
`define BOOT_START_SZ2      12'hf00
`define BOOT_START_SZ3      12'hf80
`define VEC_NUM_W           5
`define FIRST_VECTOR        5'h01
`define LAST_VECTOR         5'h12

// ------------------------------------
// Timing
// ------------------------------------
`define UNLOCK_WINDOW_CYCLES 4
`define CNT_W               3

`endif

// File: rtl/vector_placement_pkg.sv
// Types shared by the vector placement control block.
// Assumes the defs header sits in the include path.
`include "vector_placement_defs.svh"

package vector_placement_pkg;

   // -------------------------------------------------------------------
   // Change sequence states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE,   // No change sequence running
      SEQ_OPEN,   // Unlock window open
      SEQ_HOLD    // Select written, waiting for next instruction
   } seq_state_t;

   // -------------------------------------------------------------------
   // Complete state of the top module
   // -------------------------------------------------------------------
   typedef struct packed {
      seq_state_t                  seq;         // Sequence state
      logic [`CNT_W-1:0]           win_cnt;     // Window cycles left
      logic                        vsel;        // Vector base select
      logic                        irq0_en;     // External irq 0 enable
      logic                        irq1_en;     // External irq 1 enable
      logic                        mask;        // Dispatch mask output
      logic                        seq_mask;    // Mask from sequence only
      logic                        lock_block;  // Mask from lock bits
      logic [`FLASH_ADDR_W-1:0]    vec_base;    // Vector table base
      logic [`FLASH_ADDR_W-1:0]    vec_addr;    // Current vector address
      logic [`FLASH_ADDR_W-1:0]    reset_addr;  // Reset entry address
      logic [`APB_DATA_W-1:0]      prdata;      // Read data register
   } top_state_t;

endpackage : vector_placement_pkg

// File: rtl/vector_table_relocation.sv
// Vector placement control: APB control register, timed select unlock,
// dispatch masking and lock blocking.
// Assumes an APB3 master on clk_in and static fuse and lock inputs.
`timescale 1ns/1ps
`default_nettype none
`include "vector_placement_defs.svh"

module vector_table_relocation
   import vector_placement_pkg::*;
#(
   parameter int WINDOW_CYCLES = `UNLOCK_WINDOW_CYCLES   // Unlock window length
)
(
   input  wire logic                       clk_in,                    // 125 MHz clock
   input  wire logic                       rst_in,                    // Sync reset, high
   // APB slave
   input  wire logic                       psel_in,                   // Slave select
   input  wire logic                       penable_in,                // Access phase
   input  wire logic                       pwrite_in,                 // 1 = write
   input  wire logic [`APB_ADDR_W-1:0]     paddr_in,                  // Byte address
   input  wire logic [`APB_DATA_W-1:0]     pwdata_in,                 // Write data
   output logic      [`APB_DATA_W-1:0]     prdata_out,                // Read data
   output logic                            pready_out,                // Always ready
   output logic                            pslverr_out,               // Unmapped access
   // Fuses, lock bits and core status
   input  wire logic                       boot_reset_fuse_in,        // 0 = programmed
   input  wire logic [1:0]                 boot_size_fuses_in,        // Boot size code
   input  wire logic                       app_section_lock_bit_in,   // 0 = programmed
   input  wire logic                       boot_section_lock_bit_in,  // 0 = programmed
   input  wire logic                       exec_from_boot_in,         // PC in boot section
   input  wire logic                       instr_done_in,             // Instruction completed
   input  wire logic [`VEC_NUM_W-1:0]      irq_num_in,                // Vector being fetched
   // Results
   output logic                            irq_dispatch_mask_out,     // Block dispatch
   output logic                            vector_base_select_out,    // Stored select
   output logic                            vector_change_unlock_out,  // Window open
   output logic                            ext_irq0_enable_out,       // Stored enable 0
   output logic                            ext_irq1_enable_out,       // Stored enable 1
   output logic      [`FLASH_ADDR_W-1:0]   vector_base_out,           // Table base
   output logic      [`FLASH_ADDR_W-1:0]   vector_addr_out,           // Vector address
   output logic      [`FLASH_ADDR_W-1:0]   reset_addr_out             // Reset entry
);

   // --------------------------------------------------------------------
   // Elaboration checks
   // --------------------------------------------------------------------
   // Window must fit the counter and last a cycle
   if (WINDOW_CYCLES < 1 || WINDOW_CYCLES > (2**`CNT_W)-1) begin : g_bad_window
      $error("WINDOW_CYCLES out of range");
   end

   localparam logic [`CNT_W-1:0] WIN_LOAD = `CNT_W'(WINDOW_CYCLES);   // Counter load value
   localparam logic [`CNT_W-1:0] WIN_LAST = `CNT_W'(1);               // Final window cycle

   // --------------------------------------------------------------------
   // State and decode signals
   // --------------------------------------------------------------------
   top_state_t                st_ff;        // Registered state
   top_state_t                nxt_st;       // Next state
   logic                      setup_ph;     // APB setup phase
   logic                      access_ph;    // APB access phase
   logic                      hit_ctrl;     // Address is control register
   logic                      hit_status;   // Address is status register
   logic                      wr_ctrl;      // Control write takes effect
   logic                      wr_unlock;    // Written unlock bit value
   logic                      wr_vsel;      // Written select bit value
   logic [`FLASH_ADDR_W-1:0]  calc_base;    // Base from calculator
   logic [`FLASH_ADDR_W-1:0]  calc_vaddr;   // Vector address from calculator
   logic [`FLASH_ADDR_W-1:0]  calc_reset;   // Reset entry from calculator
   logic                      app_locked;   // Application lock programmed
   logic                      boot_locked;  // Boot lock programmed

   // --------------------------------------------------------------------
   // Register read image
   // --------------------------------------------------------------------
   // Reserved bits 5..2 are never stored, so they always read zero
   function automatic logic [`APB_DATA_W-1:0] ctrl_image(input top_state_t s);
      logic [`APB_DATA_W-1:0] img;
      img               = '0;
      img[`BIT_UNLOCK]  = (s.seq == SEQ_OPEN);
      img[`BIT_VSEL]    = s.vsel;
      img[`BIT_IRQ0_EN] = s.irq0_en;
      img[`BIT_IRQ1_EN] = s.irq1_en;
      return img;
   endfunction : ctrl_image

   // Status shows sequence internals for debug
   function automatic logic [`APB_DATA_W-1:0] status_image(input top_state_t s);
      logic [`APB_DATA_W-1:0] img;
      img                                        = '0;
      img[`ST_SEQ_MASK]                          = s.seq_mask;
      img[`ST_LOCK_BLOCK]                        = s.lock_block;
      img[`ST_HOLD]                              = (s.seq == SEQ_HOLD);
      img[`ST_CNT_LSB +: `CNT_W]                 = s.win_cnt;
      img[`ST_BASE_LSB +: `FLASH_ADDR_W]         = s.vec_base;
      return img;
   endfunction : status_image

   // --------------------------------------------------------------------
   // Address arithmetic
   // --------------------------------------------------------------------
   // Calculator sees the stored select: a new base lags the write
   vector_address_calc u_calc (
      .boot_size_fuses_in    (boot_size_fuses_in),
      .boot_reset_fuse_in    (boot_reset_fuse_in),
      .vector_base_select_in (st_ff.vsel),
      .irq_num_in            (irq_num_in),
      .vector_base_out       (calc_base),
      .vector_addr_out       (calc_vaddr),
      .reset_addr_out        (calc_reset)
   );

   // --------------------------------------------------------------------
   // APB decode
   // --------------------------------------------------------------------
   // Zero wait states
   always_comb begin
      setup_ph    = psel_in & ~penable_in;
      access_ph   = psel_in & penable_in;
      hit_ctrl    = (paddr_in == `CTRL_OFFSET);
      hit_status  = (paddr_in == `STATUS_OFFSET);
      wr_ctrl     = access_ph & pwrite_in & hit_ctrl;
      wr_unlock   = pwdata_in[`BIT_UNLOCK];
      wr_vsel     = pwdata_in[`BIT_VSEL];
      // Lock bits are programmed when they read zero
      app_locked  = ~app_section_lock_bit_in;
      boot_locked = ~boot_section_lock_bit_in;
      pready_out  = 1'b1;
      // Unmapped: error, reads zero
      pslverr_out = access_ph & ~hit_ctrl & ~hit_status;
   end

   // --------------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // Interrupt enable bits are plain read-write storage
      if (wr_ctrl) begin
         nxt_st.irq0_en = pwdata_in[`BIT_IRQ0_EN];
         nxt_st.irq1_en = pwdata_in[`BIT_IRQ1_EN];
      end

      // Change sequence
      unique case (st_ff.seq)
         SEQ_IDLE: begin
            // Unlock opens; its select bit is dropped so one write cannot move the table
            if (wr_ctrl && wr_unlock) begin
               nxt_st.seq     = SEQ_OPEN;
               nxt_st.win_cnt = WIN_LOAD;
            end
         end
         SEQ_OPEN: begin
            if (wr_ctrl && !wr_unlock) begin
               // Completing write: select lands, unlock drops at once
               nxt_st.vsel    = wr_vsel;
               nxt_st.seq     = SEQ_HOLD;
               nxt_st.win_cnt = '0;
            end else if (wr_ctrl && wr_unlock) begin
               // Unlock written again: window restarts, select ignored
               nxt_st.win_cnt = WIN_LOAD;
            end else if (st_ff.win_cnt == WIN_LAST) begin
               // Window expired without a select write
               nxt_st.seq     = SEQ_IDLE;
               nxt_st.win_cnt = '0;
            end else begin
               nxt_st.win_cnt = st_ff.win_cnt - WIN_LAST;
            end
         end
         SEQ_HOLD: begin
            // Mask held until the instruction after the select write ends
            if (wr_ctrl && wr_unlock) begin
               nxt_st.seq     = SEQ_OPEN;
               nxt_st.win_cnt = WIN_LOAD;
            end else if (instr_done_in) begin
               nxt_st.seq     = SEQ_IDLE;
            end
         end
      endcase

      // Mask gates dispatch only; the core's global flag is untouched
      nxt_st.seq_mask = (nxt_st.seq != SEQ_IDLE);

      // Lock blocking depends on where the table sits and where code runs
      nxt_st.lock_block = ( nxt_st.vsel & app_locked  & ~exec_from_boot_in)
                        | (~nxt_st.vsel & boot_locked &  exec_from_boot_in);
      nxt_st.mask       = nxt_st.seq_mask | nxt_st.lock_block;

      // Address results are registered copies of the calculator
      nxt_st.vec_base   = calc_base;
      nxt_st.vec_addr   = calc_vaddr;
      nxt_st.reset_addr = calc_reset;

      // Read data is captured in the setup phase and held through access
      if (setup_ph && !pwrite_in) begin
         if (hit_ctrl) begin
            nxt_st.prdata = ctrl_image(st_ff);
         end else if (hit_status) begin
            nxt_st.prdata = status_image(st_ff);
         end else begin
            nxt_st.prdata = '0;
         end
      end
   end

   // --------------------------------------------------------------------
   // State register
   // --------------------------------------------------------------------
   // Constants only; fuse-derived values follow the release edge
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_ff.seq        <= SEQ_IDLE;
         st_ff.win_cnt    <= '0;
         st_ff.vsel       <= 1'(`CTRL_RESET >> `BIT_VSEL);
         st_ff.irq0_en    <= 1'b0;
         st_ff.irq1_en    <= 1'b0;
         st_ff.mask       <= 1'b0;
         st_ff.seq_mask   <= 1'b0;
         st_ff.lock_block <= 1'b0;
         st_ff.vec_base   <= `FLASH_RESET_ADDR;
         st_ff.vec_addr   <= `FLASH_RESET_ADDR;
         st_ff.reset_addr <= `FLASH_RESET_ADDR;
         st_ff.prdata     <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------
   // All data outputs come straight from the state register
   always_comb begin
      prdata_out               = st_ff.prdata;
      irq_dispatch_mask_out    = st_ff.mask;
      vector_base_select_out   = st_ff.vsel;
      vector_change_unlock_out = (st_ff.seq == SEQ_OPEN);
      ext_irq0_enable_out      = st_ff.irq0_en;
      ext_irq1_enable_out      = st_ff.irq1_en;
      vector_base_out          = st_ff.vec_base;
      vector_addr_out          = st_ff.vec_addr;
      reset_addr_out           = st_ff.reset_addr;
   end

endmodule : vector_table_relocation
`default_nettype wire

// File: sim/core_model.sv
// Core model: one completion pulse per three-cycle instruction.
// Assumes run_in is driven just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic  clk_in,          // System clock
   input  wire logic  rst_in,          // Sync reset, high
   input  wire logic  run_in,          // Core executing
   output logic       instr_done_out   // Instruction completed
);
   logic [1:0] ph_ff;  // Phase inside the current instruction
   // A stalled core completes nothing, so the phase restarts
   always_ff @(posedge clk_in) begin
      if (rst_in || !run_in) ph_ff <= 2'h0;
      else ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
   end
   assign instr_done_out = run_in && (ph_ff == 2'h2);
endmodule : core_model
`default_nettype wire

// File: sim/vector_table_relocation_checker.sv
// Checker of vector placement: sequence, mask, addresses.
// Assumes bind into the top; fuses change only in reset.
`timescale 1ns/1ps
`default_nettype none
`include "vector_placement_defs.svh"
module vector_table_relocation_checker
   import vector_placement_pkg::*;
#(parameter int WINDOW_CYCLES = 4)
(
   input wire logic                      clk_in,
   input wire logic                      rst_in,
   input wire logic                      psel_in,
   input wire logic                      penable_in,
   input wire logic                      pwrite_in,
   input wire logic [`APB_ADDR_W-1:0]    paddr_in,
   input wire logic [`APB_DATA_W-1:0]    pwdata_in,
   input wire logic                      boot_reset_fuse_in,
   input wire logic [1:0]                boot_size_fuses_in,
   input wire logic                      app_section_lock_bit_in,
   input wire logic                      boot_section_lock_bit_in,
   input wire logic                      exec_from_boot_in,
   input wire logic                      instr_done_in,
   input wire logic [`VEC_NUM_W-1:0]     irq_num_in,
   input wire logic                      irq_dispatch_mask_out,
   input wire logic                      vector_base_select_out,
   input wire logic                      vector_change_unlock_out,
   input wire logic [`FLASH_ADDR_W-1:0]  vector_base_out,
   input wire logic [`FLASH_ADDR_W-1:0]  vector_addr_out,
   input wire logic [`FLASH_ADDR_W-1:0]  reset_addr_out
);
   // ------------------------------------
   // Helper logic
   // ------------------------------------
   logic                      ctrl_wr;     // Control write at its access edge
   logic                      lock_on;     // Lock bits forbid dispatch here
   logic [`FLASH_ADDR_W-1:0]  boot_start;  // Boot section start word
   logic [3:0]                cnt_ff;      // Cycles since the last unlock write
   assign ctrl_wr = psel_in && penable_in && pwrite_in && (paddr_in == `CTRL_OFFSET);
   assign lock_on = vector_base_select_out ? (!app_section_lock_bit_in && !exec_from_boot_in)
                                           : (!boot_section_lock_bit_in && exec_from_boot_in);
   assign boot_start = boot_size_fuses_in[1] ? (boot_size_fuses_in[0] ? `BOOT_START_SZ3 : `BOOT_START_SZ2)
                                             : (boot_size_fuses_in[0] ? `BOOT_START_SZ1 : `BOOT_START_SZ0);
   // Saturates so idle cannot wrap into the window
   always_ff @(posedge clk_in) begin
      if (rst_in || (ctrl_wr && pwdata_in[0])) cnt_ff <= 4'h0;
      else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ------------------------------------
   // Assertions
   // ------------------------------------
   a_unlock_opens: assert property (ctrl_wr && pwdata_in[0] |=> vector_change_unlock_out && irq_dispatch_mask_out)
      else $error("no unlock");
   a_window_short: assert property (vector_change_unlock_out |-> cnt_ff < WINDOW_CYCLES)
      else $error("window open too long");
   a_window_full: assert property ($fell(vector_change_unlock_out) |-> cnt_ff == WINDOW_CYCLES || $past(ctrl_wr))
      else $error("window closed early");
   a_select_taken: assert property (ctrl_wr && !pwdata_in[0] && vector_change_unlock_out |=>
      !vector_change_unlock_out && vector_base_select_out == $past(pwdata_in[1])) else $error("select not taken");
   a_select_kept: assert property (ctrl_wr && (pwdata_in[0] || !vector_change_unlock_out) |=>
      $stable(vector_base_select_out)) else $error("select moved");
   a_mask_window: assert property (vector_change_unlock_out |-> irq_dispatch_mask_out)
      else $error("dispatch open in window");
   a_mask_hold: assert property (ctrl_wr && !pwdata_in[0] && vector_change_unlock_out ##1 !instr_done_in
      |=> irq_dispatch_mask_out) else $error("mask dropped");
   a_base_value: assert property (vector_base_select_out == $past(vector_base_select_out) |->
      vector_base_out == (vector_base_select_out ? boot_start : `FLASH_RESET_ADDR)) else $error("bad vector base");
   a_reset_entry: assert property (!$past(rst_in) |->
      reset_addr_out == (boot_reset_fuse_in ? `FLASH_RESET_ADDR : boot_start)) else $error("bad reset entry");
   a_lock_block: assert property (!$past(rst_in) && lock_on && $past(lock_on) |-> irq_dispatch_mask_out)
      else $error("no lock block");
   a_vector_step: assert property (!$past(rst_in) && $stable(irq_num_in) && $stable(vector_base_out) &&
      irq_num_in inside {[5'h01:5'h12]} |-> vector_addr_out == vector_base_out + irq_num_in) else $error("bad vector");
endmodule : vector_table_relocation_checker
bind vector_table_relocation vector_table_relocation_checker #(.WINDOW_CYCLES(WINDOW_CYCLES)) checker_inst (.*);
`default_nettype wire

// File: sim/vector_table_relocation_tb.sv
// Bench of vector placement with a core model.
// Assumes all other files compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "vector_placement_defs.svh"
module vector_table_relocation_tb;
   logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic boot_reset_fuse_in = 1'b1, app_section_lock_bit_in = 1'b1, boot_section_lock_bit_in = 1'b1;
   logic exec_from_boot_in = 1'b0, run_in = 1'b0, pready_out, pslverr_out, instr_done_in, er;
   logic irq_dispatch_mask_out, vector_base_select_out, vector_change_unlock_out;
   logic ext_irq0_enable_out, ext_irq1_enable_out;
   logic [1:0] boot_size_fuses_in = 2'h0;
   logic [`VEC_NUM_W-1:0] irq_num_in = 5'h01;
   logic [`APB_ADDR_W-1:0] paddr_in = 12'h000;
   logic [`APB_DATA_W-1:0] pwdata_in = 32'h0, prdata_out, rd;
   logic [`FLASH_ADDR_W-1:0] vector_base_out, vector_addr_out, reset_addr_out;
   int miscompares = 0, comparisons = 0, cycles = 0, n;
   vector_table_relocation #(.WINDOW_CYCLES(4)) vector_table_relocation_inst (.*);
   core_model core_model_inst (.clk_in(clk_in), .rst_in(rst_in), .run_in(run_in), .instr_done_out(instr_done_in));
   always #4 clk_in = ~clk_in;
   // Hang guard; tests need ~100 cycles
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares = miscompares + 1;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One APB transfer; rd and er taken at the ready edge
   task automatic apb(input logic w, input logic [`APB_ADDR_W-1:0] a, input logic [`APB_DATA_W-1:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   // Waits k cycles, to the falling edge
   task automatic settle(input int k);
      repeat (k) @(negedge clk_in);
   endtask : settle
   task automatic t_regs();
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      apb(1'b1, `CTRL_OFFSET, 32'hfe);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk("ctrl bits", rd, 32'hc0);
      chk("enables", {ext_irq1_enable_out, ext_irq0_enable_out}, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      chk("slverr", er, 32'h1);
      $display("test regs done");
   endtask : t_regs
   task automatic t_timeout();
      apb(1'b1, `CTRL_OFFSET, 32'h03);
      n = 0;
      repeat (8) begin
         settle(1);
         n += int'(vector_change_unlock_out) + 16 * int'(irq_dispatch_mask_out);
      end
      chk("win mask cycles", n, 32'h44);
      chk("select kept", vector_base_select_out, 32'h0);
      $display("test timeout done");
   endtask : t_timeout
   // Select change; the core stalls so the mask waits
   task automatic t_move(input logic v);
      apb(1'b1, `CTRL_OFFSET, 32'h01);
      settle(1);
      chk("mask in window", irq_dispatch_mask_out, 32'h1);
      apb(1'b1, `CTRL_OFFSET, {30'h0, v, 1'b0});
      settle(3);
      chk("select", vector_base_select_out, v);
      chk("unlock", vector_change_unlock_out, 32'h0);
      chk("mask held", irq_dispatch_mask_out, 32'h1);
      @(posedge clk_in);
      run_in <= 1'b1;
      n = 0;
      while (irq_dispatch_mask_out === 1'b1 && n < 20) begin
         settle(1);
         n++;
      end
      chk("mask free", irq_dispatch_mask_out, 32'h0);
      chk("base", vector_base_out, v ? `BOOT_START_SZ0 : `FLASH_RESET_ADDR);
      @(posedge clk_in);
      run_in <= 1'b0;
      irq_num_in <= 5'h12;
      settle(2);
      chk("last vector", vector_addr_out, v ? 32'hc12 : 32'h012);
      @(posedge clk_in);
      irq_num_in <= 5'h01;
      settle(2);
      chk("first vector", vector_addr_out, v ? 32'hc01 : 32'h001);
      $display("test move done");
   endtask : t_move
   // One lock programmed: blocks only the far section
   task automatic t_lock(input logic boot);
      @(posedge clk_in);
      app_section_lock_bit_in <= boot;
      boot_section_lock_bit_in <= !boot;
      exec_from_boot_in <= boot;
      settle(2);
      chk("lock block", irq_dispatch_mask_out, 32'h1);
      @(posedge clk_in);
      exec_from_boot_in <= !boot;
      settle(2);
      chk("lock free", irq_dispatch_mask_out, 32'h0);
      @(posedge clk_in);
      app_section_lock_bit_in <= 1'b1;
      boot_section_lock_bit_in <= 1'b1;
      $display("test lock done");
   endtask : t_lock
   task automatic t_fuses();
      logic [`FLASH_ADDR_W-1:0] bs [4];
      bs = '{`BOOT_START_SZ0, `BOOT_START_SZ1, `BOOT_START_SZ2, `BOOT_START_SZ3};
      for (int k = 0; k < 5; k++) begin
         @(posedge clk_in);
         rst_in <= 1'b1;
         boot_reset_fuse_in <= (k == 4);
         boot_size_fuses_in <= k[1:0];
         repeat (3) @(posedge clk_in);
         rst_in <= 1'b0;
         settle(2);
         chk("reset entry", reset_addr_out, (k == 4) ? `FLASH_RESET_ADDR : bs[k[1:0]]);
      end
      $display("test fuses done");
   endtask : t_fuses
   initial begin
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs();
      t_timeout();
      t_move(1'b1);
      t_lock(1'b0);
      t_move(1'b0);
      t_lock(1'b1);
      t_fuses();
      complete_run();
   end
endmodule : vector_table_relocation_tb
`default_nettype wire
